// File: psfp_pkg.sv
package psfp_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_HB = 4;
    localparam int NUM_CH = 2;
    localparam int OL_W = 6;
    localparam logic [5:0] OL_MAX = 6'h3F;
    localparam logic [5:0] OL_RST = 6'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS = 100;
    localparam int STEP_NS = 1000;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int FRAME_TO_NS = 20000;
    localparam int FRAME_TO_CYC = FRAME_TO_NS / CLK_NS;

    // ****************************************
    // Overcurrent adjust codes (3 bits): bit2 = latched mode
    // ****************************************
    localparam int OCSEL_W = 3;
    localparam int OCSEL_LATCH_BIT = 2;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_OLCNT = 12'h008;
    localparam int CTRL_OCSEL_LSB = 0;
    localparam int CTRL_DCPROT_BIT = 3;
    localparam int CTRL_SE_BIT = 4;
    localparam logic [4:0] CTRL_RST = 5'h08;

    typedef enum logic [1:0] {
        PSC_GND,
        PSC_SUPPLY,
        PSC_DONE
    } psc_state_t;

endpackage

// File: power_stage_fault_protection.sv
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module power_stage_fault_protection
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Device pins and comparators
    input wire logic reset_pin_n,
    input wire logic [3:0] frame_start,
    input wire logic [3:0] pwm_in,
    input wire logic [3:0] oc_event,
    input wire logic [1:0] dc_imbalance,
    input wire logic temp_warn_cmp,
    input wire logic temp_sd_cmp,
    input wire logic supply_ok,
    input wire logic short_gnd_cmp,
    input wire logic short_sup_cmp,
    // Power stage
    output logic [3:0] hb_out,
    output logic [3:0] hb_hiz,
    // Open-drain status pins
    output logic fault_n_o,
    output logic fault_n_oe,
    output logic temp_warning_n_o,
    output logic temp_warning_n_oe
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [13:0] sync1_r;
    logic [13:0] sync2_r;
    logic [13:0] pin_raw;
    assign pin_raw = {pwm_in, short_sup_cmp, short_gnd_cmp, supply_ok, temp_sd_cmp,
                      temp_warn_cmp, dc_imbalance, reset_pin_n, 2'h0};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_r <= 14'h0000;
            sync2_r <= 14'h0000;
        end
        else if (clk_en)
        begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    logic [3:0] pwm_s;
    logic sup_s, gnd_s, sok_s, tsd_s, twarn_s, rstn_s;
    logic [1:0] dc_s;
    assign pwm_s = sync2_r[13:10];
    assign sup_s = sync2_r[9];
    assign gnd_s = sync2_r[8];
    assign sok_s = sync2_r[7];
    assign tsd_s = sync2_r[6];
    assign twarn_s = sync2_r[5];
    assign dc_s = sync2_r[4:3];
    assign rstn_s = sync2_r[2];

    // ****************************************
    // Registers
    // ****************************************
    logic [4:0] ctrl_r;
    logic [2:0] ocsel;
    logic latched_mode, dc_prot_en, se_mode;
    assign ocsel = ctrl_r[psfp_pkg::CTRL_OCSEL_LSB +: psfp_pkg::OCSEL_W];
    assign latched_mode = ocsel[psfp_pkg::OCSEL_LATCH_BIT];
    assign dc_prot_en = ctrl_r[psfp_pkg::CTRL_DCPROT_BIT];
    assign se_mode = ctrl_r[psfp_pkg::CTRL_SE_BIT];

    logic dph_r, dwr_r;
    logic [11:0] daddr_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dph_r <= 1'b0;
            dwr_r <= 1'b0;
            daddr_r <= 12'h000;
        end
        else if (clk_en && hready)
        begin
            dph_r <= hsel && htrans[1];
            dwr_r <= hwrite;
            daddr_r <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_r <= psfp_pkg::CTRL_RST;
        else if (clk_en && dph_r && dwr_r && daddr_r == psfp_pkg::ADDR_CTRL)
            ctrl_r <= hwdata[4:0];
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ****************************************
    // Reset pin edge and startup
    // ****************************************
    logic rstn_d_r;
    logic psc_busy, dev_rst;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rstn_d_r <= 1'b0;
        else if (clk_en)
            rstn_d_r <= rstn_s;
    end
    assign dev_rst = !rstn_s && !psc_busy;

    logic running_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            running_r <= 1'b0;
        else if (clk_en)
        begin
            if (dev_rst)
                running_r <= 1'b0;
            else if (rstn_s && !rstn_d_r && !psc_busy)
                running_r <= 1'b1;
        end
    end

    // ****************************************
    // Pin-short check, once after power-on
    // ****************************************
    psfp_pkg::psc_state_t psc_r;
    logic [7:0] step_r;
    logic short_found;
    assign psc_busy = psc_r != psfp_pkg::PSC_DONE;
    assign short_found = (psc_r == psfp_pkg::PSC_GND && gnd_s) ||
                         (psc_r == psfp_pkg::PSC_SUPPLY && sup_s);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            psc_r <= psfp_pkg::PSC_GND;
            step_r <= 8'h00;
        end
        else if (clk_en && psc_busy && sok_s)
        begin
            if (se_mode)
                psc_r <= psfp_pkg::PSC_DONE;
            else if (short_found)
                step_r <= 8'h00;
            else if (step_r == 8'(psfp_pkg::STEP_CYC - 1))
            begin
                step_r <= 8'h00;
                case (psc_r)
                    psfp_pkg::PSC_GND: psc_r <= psfp_pkg::PSC_SUPPLY;
                    default: psc_r <= psfp_pkg::PSC_DONE;
                endcase
            end
            else
                step_r <= step_r + 8'h01;
        end
    end

    // ****************************************
    // Thermal latch
    // ****************************************
    logic tsd_latch_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tsd_latch_r <= 1'b0;
        else if (clk_en)
        begin
            if (tsd_s)
                tsd_latch_r <= 1'b1;
            else if (dev_rst)
                tsd_latch_r <= 1'b0;
        end
    end

    // ****************************************
    // Per half-bridge current limiting and per-channel overload
    // ****************************************
    logic [3:0] flip_r;
    logic [3:0] oc_seen_r;
    logic [3:0] oc_s;
    logic [5:0] olcnt_r [psfp_pkg::NUM_CH];
    logic [1:0] ol_latch_r;
    logic [3:0] stuck;
    logic [7:0] frame_cnt_r [psfp_pkg::NUM_HB];

    // Overcurrent and frame starts come from on-chip logic on hclk
    assign oc_s = oc_event & {4{running_r}};

    for (genvar h = 0; h < psfp_pkg::NUM_HB; h++)
    begin : g_hb
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                flip_r[h] <= 1'b0;
                oc_seen_r[h] <= 1'b0;
                frame_cnt_r[h] <= 8'h00;
            end
            else if (clk_en)
            begin
                if (frame_start[h])
                begin
                    flip_r[h] <= 1'b0;
                    oc_seen_r[h] <= oc_s[h];
                    frame_cnt_r[h] <= 8'h00;
                end
                else
                begin
                    if (oc_s[h] && !latched_mode)
                        flip_r[h] <= 1'b1;
                    if (oc_s[h])
                        oc_seen_r[h] <= 1'b1;
                    if (frame_cnt_r[h] != 8'(psfp_pkg::FRAME_TO_CYC))
                        frame_cnt_r[h] <= frame_cnt_r[h] + 8'h01;
                end
            end
        end
        assign stuck[h] = frame_cnt_r[h] == 8'(psfp_pkg::FRAME_TO_CYC);
    end

    for (genvar c = 0; c < psfp_pkg::NUM_CH; c++)
    begin : g_ch
        logic oc_any, frame_any, dc_hit;
        assign oc_any = oc_s[2*c] | oc_s[2*c+1];
        assign frame_any = frame_start[2*c];
        assign dc_hit = dc_prot_en && dc_s[c] && running_r && frame_any;
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                olcnt_r[c] <= psfp_pkg::OL_RST;
                ol_latch_r[c] <= 1'b0;
            end
            else if (clk_en)
            begin
                if (dev_rst)
                begin
                    olcnt_r[c] <= psfp_pkg::OL_RST;
                    ol_latch_r[c] <= 1'b0;
                end
                else if (latched_mode && oc_any)
                    ol_latch_r[c] <= 1'b1;
                else if (olcnt_r[c] == psfp_pkg::OL_MAX)
                    ol_latch_r[c] <= 1'b1;
                else if ((oc_any && !latched_mode) || dc_hit)
                    olcnt_r[c] <= olcnt_r[c] + 6'h01;
                else if (frame_any && !oc_seen_r[2*c] && !oc_seen_r[2*c+1]
                         && olcnt_r[c] != psfp_pkg::OL_RST)
                    olcnt_r[c] <= olcnt_r[c] - 6'h01;
            end
        end
    end

    // ****************************************
    // Output stage control
    // ****************************************
    logic global_off, ol_any;
    assign global_off = !sok_s || tsd_latch_r || psc_busy || !running_r;
    assign ol_any = |ol_latch_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hb_out <= 4'h0;
            hb_hiz <= 4'hF;
        end
        else if (clk_en)
        begin
            hb_out <= pwm_s ^ flip_r;
            hb_hiz <= {4{global_off}} | stuck
                      | {{2{ol_latch_r[1]}}, {2{ol_latch_r[0]}}};
        end
    end

    // ****************************************
    // Status pins
    // ****************************************
    logic fault_act_r, warn_act_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fault_act_r <= 1'b0;
            warn_act_r <= 1'b0;
        end
        else if (clk_en)
        begin
            // Reset forces fault inactive except during the short check
            fault_act_r <= psc_busy || (!dev_rst && (!sok_s || tsd_latch_r || ol_any));
            warn_act_r <= twarn_s;
        end
    end
    assign fault_n_o = 1'b0;
    assign fault_n_oe = fault_act_r;
    assign temp_warning_n_o = 1'b0;
    assign temp_warning_n_oe = warn_act_r;

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (clk_en && hready && hsel && htrans[1] && !hwrite)
        begin
            if (haddr == psfp_pkg::ADDR_CTRL)
                hrdata <= {27'h0, ctrl_r};
            else if (haddr == psfp_pkg::ADDR_STATUS)
                hrdata <= {24'h0, psc_busy, running_r, !sok_s, tsd_latch_r,
                           twarn_s, 1'b0, ol_latch_r};
            else if (haddr == psfp_pkg::ADDR_OLCNT)
                hrdata <= {18'h0, olcnt_r[1], 2'h0, olcnt_r[0]};
            else
                hrdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_PSC_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && psc_busy |=> fault_n_oe)
        else $error("fault not driven during pin-short check");
    AST_RST_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && dev_rst |=> !fault_n_oe)
        else $error("fault driven while reset held");
    AST_TSD_HIZ: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && tsd_latch_r |=> hb_hiz == 4'hF)
        else $error("outputs active in thermal shutdown");
    AST_UV_HIZ: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && !sok_s |=> hb_hiz == 4'hF && fault_n_oe == !$past(dev_rst))
        else $error("undervoltage response wrong");
    AST_FLIP_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && frame_start[0] |=> !flip_r[0])
        else $error("flip not cleared at frame start");
    AST_LATCHED: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && latched_mode && oc_s[2] && !dev_rst |=> ol_latch_r[1])
        else $error("latched mode did not shut down");
    AST_OLMAX: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && olcnt_r[1] == psfp_pkg::OL_MAX && !dev_rst |=> ##1 hb_hiz[3:2] == 2'h3)
        else $error("channel not shut at counter maximum");
    AST_WARN: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && twarn_s |=> temp_warning_n_oe)
        else $error("warning not asserted");
    AST_PSC_ONCE: assert property (@(posedge hclk) disable iff (!hresetn)
        !psc_busy |=> !psc_busy)
        else $error("pin-short check restarted");

endmodule

// File: pwm_source.sv
`timescale 1ns/1ns
module pwm_source
#(
    parameter int FRAME = 40
)
(
    // Clock and control
    input wire logic hclk,
    input wire logic run,
    // Open-drain status drivers
    input wire logic fault_n_o,
    input wire logic fault_n_oe,
    input wire logic temp_warning_n_o,
    input wire logic temp_warning_n_oe,
    // Towards the power stage
    output logic [3:0] frame_start,
    output logic [3:0] pwm_in,
    // Pins as the controller sees them
    output logic fault_n,
    output logic temp_warning_n,
    output logic reduce_power
);
    int cnt = 0;

    // Pull-ups: a released pin reads high
    assign fault_n = fault_n_oe ? fault_n_o : 1'b1;
    assign temp_warning_n = temp_warning_n_oe ? temp_warning_n_o : 1'b1;
    // Controller backs off volume while the warning is low
    assign reduce_power = !temp_warning_n;

    initial
    begin
        frame_start = 4'h0;
        pwm_in = 4'h0;
    end

    // Frames stop and PWM holds while run is low
    always @(posedge hclk)
    begin
        cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
        frame_start <= (run && cnt == 0) ? 4'hF : 4'h0;
        if (run && (cnt == 0 || cnt == FRAME / 2))
        begin
            pwm_in <= ~pwm_in;
        end
    end
endmodule

// File: testbench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, reset_pin_n, run;
    logic [11:0] haddr;
    logic [1:0] htrans, dc_imbalance;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [3:0] frame_start, pwm_in, oc_event, hb_out, hb_hiz;
    logic temp_warn_cmp, temp_sd_cmp, supply_ok, short_gnd_cmp, short_sup_cmp;
    logic fault_n_o, fault_n_oe, tw_o, tw_oe, fault_n, temp_warning_n, reduce_power;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    power_stage_fault_protection power_stage_fault_protection_inst (.hclk(hclk),
        .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reset_pin_n(reset_pin_n),
        .frame_start(frame_start), .pwm_in(pwm_in), .oc_event(oc_event),
        .dc_imbalance(dc_imbalance), .temp_warn_cmp(temp_warn_cmp),
        .temp_sd_cmp(temp_sd_cmp), .supply_ok(supply_ok), .short_gnd_cmp(short_gnd_cmp),
        .short_sup_cmp(short_sup_cmp), .hb_out(hb_out), .hb_hiz(hb_hiz),
        .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .temp_warning_n_o(tw_o),
        .temp_warning_n_oe(tw_oe));

    pwm_source pwm_source_inst (.hclk(hclk), .run(run), .fault_n_o(fault_n_o),
        .fault_n_oe(fault_n_oe), .temp_warning_n_o(tw_o), .temp_warning_n_oe(tw_oe),
        .frame_start(frame_start), .pwm_in(pwm_in), .fault_n(fault_n),
        .temp_warning_n(temp_warning_n), .reduce_power(reduce_power));

    always #50 hclk = ~hclk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test();
        $display("comparisons=%0d mismatches=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            $display("timeout at %0t", $time);
            end_of_test();
        end
    end

    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= we;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    task automatic midframe();
        @(posedge frame_start[0]);
        wt(10);
    endtask

    task automatic oc_pulse(input logic [3:0] m);
        oc_event <= m;
        @(posedge hclk);
        oc_event <= 4'h0;
        wt(5);
    endtask

    task automatic rcycle();
        @(posedge hclk);
        reset_pin_n <= 1'b0;
        wt(6);
        `CHK(fault_n, 1'b1)
        reset_pin_n <= 1'b1;
        for (int i = 0; i < 400 && hb_hiz !== 4'h0; i++) @(posedge hclk);
        `CHK(hb_hiz, 4'h0)
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_startup();
        logic [31:0] q;
        wt(8);
        `CHK(fault_n, 1'b0)
        `CHK(hb_hiz, 4'hF)
        reset_pin_n <= 1'b1;
        bus(1'b0, psfp_pkg::ADDR_OLCNT, 32'h0, q);
        `CHK(q, 32'h00000000)
        bus(1'b0, psfp_pkg::ADDR_CTRL, 32'h0, q);
        `CHK(q, 32'h00000008)
        bus(1'b1, 12'h00C, 32'hFFFFFFFF, q);
        bus(1'b0, 12'h00C, 32'h0, q);
        `CHK(q, 32'h00000000)
        `CHK(hresp, 1'b0)
        bus(1'b0, psfp_pkg::ADDR_STATUS, 32'h0, q);
        `CHK(q[7], 1'b1)
        short_gnd_cmp <= 1'b0;
        short_sup_cmp <= 1'b1;
        wt(40);
        bus(1'b0, psfp_pkg::ADDR_STATUS, 32'h0, q);
        `CHK(q[7], 1'b1)
        `CHK(fault_n, 1'b0)
        short_sup_cmp <= 1'b0;
        for (int i = 0; i < 60 && q[7] !== 1'b0; i++)
            bus(1'b0, psfp_pkg::ADDR_STATUS, 32'h0, q);
        wt(4);
        `CHK(fault_n, 1'b1)
        `CHK(hb_hiz, 4'hF)
        rcycle();
        `CHK({fault_n, temp_warning_n}, 2'b11)
        $display("startup test done");
    endtask

    task automatic t_cycle();
        logic [31:0] q;
        midframe();
        oc_pulse(4'h1);
        `CHK(hb_out[0] ^ hb_out[1], 1'b1)
        bus(1'b0, psfp_pkg::ADDR_OLCNT, 32'h0, q);
        `CHK(q[5:0], 6'h01)
        @(posedge frame_start[0]);
        wt(5);
        `CHK(hb_out[0] ^ hb_out[1], 1'b0)
        wt(90);
        bus(1'b0, psfp_pkg::ADDR_OLCNT, 32'h0, q);
        `CHK(q[5:0], 6'h00)
        $display("cycle limit test done");
    endtask

    task automatic t_overload();
        logic [31:0] q;
        midframe();
        oc_event <= 4'h1;
        wt(120);
        oc_event <= 4'h0;
        wt(5);
        `CHK(hb_hiz, 4'h3)
        `CHK({fault_n, temp_warning_n}, 2'b01)
        bus(1'b0, psfp_pkg::ADDR_OLCNT, 32'h0, q);
        `CHK(q[5:0], psfp_pkg::OL_MAX)
        wt(100);
        `CHK(hb_hiz, 4'h3)
        rcycle();
        $display("overload test done");
    endtask

    task automatic t_modes();
        logic [31:0] q;
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, psfp_pkg::ADDR_CTRL, {28'h0, 1'b1, c[2:0]}, q);
            midframe();
            oc_pulse(4'h4);
            `CHK(hb_hiz, {c[2], c[2], 2'b00})
            `CHK(fault_n, ~c[2])
            if (c[2])
                rcycle();
        end
        $display("mode select test done");
    endtask

    task automatic t_dc();
        logic [31:0] q;
        bus(1'b1, psfp_pkg::ADDR_CTRL, 32'h00000008, q); // First scheme only
        dc_imbalance <= 2'h2;
        for (int i = 0; i < 3000 && hb_hiz[3] !== 1'b1; i++) @(posedge hclk);
        wt(2);
        `CHK(hb_hiz, 4'hC)
        bus(1'b0, psfp_pkg::ADDR_STATUS, 32'h0, q);
        `CHK(q[1:0], 2'h2)
        dc_imbalance <= 2'h0;
        rcycle();
        $display("dc guard test done");
    endtask

    task automatic t_thermal();
        temp_warn_cmp <= 1'b1;
        wt(6);
        `CHK({fault_n, temp_warning_n}, 2'b10)
        `CHK(hb_hiz, 4'h0)
        `CHK(reduce_power, 1'b1)
        temp_sd_cmp <= 1'b1;
        wt(6);
        `CHK({fault_n, temp_warning_n}, 2'b00)
        `CHK(hb_hiz, 4'hF)
        temp_sd_cmp <= 1'b0;
        temp_warn_cmp <= 1'b0;
        wt(20);
        `CHK({fault_n, temp_warning_n}, 2'b01)
        `CHK(hb_hiz, 4'hF)
        rcycle();
        $display("thermal test done");
    endtask

    task automatic t_supply();
        supply_ok <= 1'b0;
        wt(6);
        `CHK(hb_hiz, 4'hF)
        `CHK({fault_n, temp_warning_n}, 2'b01)
        reset_pin_n <= 1'b0;
        wt(6);
        `CHK(fault_n, 1'b1)
        reset_pin_n <= 1'b1;
        wt(6);
        `CHK(fault_n, 1'b0)
        supply_ok <= 1'b1;
        for (int i = 0; i < 400 && hb_hiz !== 4'h0; i++) @(posedge hclk);
        wt(2);
        `CHK(hb_hiz, 4'h0)
        `CHK(fault_n, 1'b1)
        $display("supply test done");
    endtask

    task automatic t_nopwm();
        logic [31:0] q;
        run <= 1'b0;
        wt(260);
        `CHK(hb_hiz, 4'hF)
        run <= 1'b1;
        for (int i = 0; i < 400 && hb_hiz !== 4'h0; i++) @(posedge hclk);
        `CHK(hb_hiz, 4'h0)
        short_gnd_cmp <= 1'b1;
        rcycle();
        bus(1'b0, psfp_pkg::ADDR_STATUS, 32'h0, q);
        `CHK(q[7], 1'b0)
        `CHK(fault_n, 1'b1)
        // Power-on clearing restarts the check; single-ended mode skips it
        hresetn <= 1'b0;
        wt(2);
        hresetn <= 1'b1;
        bus(1'b0, psfp_pkg::ADDR_STATUS, 32'h0, q);
        `CHK(q[7], 1'b1)
        bus(1'b1, psfp_pkg::ADDR_CTRL, 32'h00000018, q);
        bus(1'b0, psfp_pkg::ADDR_STATUS, 32'h0, q);
        `CHK(q[7], 1'b0)
        short_gnd_cmp <= 1'b0;
        $display("frame loss and recheck test done");
    endtask

    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {reset_pin_n, oc_event, dc_imbalance, temp_warn_cmp, temp_sd_cmp} = '0;
        {short_sup_cmp, supply_ok, short_gnd_cmp, run} = 4'h7;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_startup();
        t_cycle();
        t_overload();
        t_modes();
        t_dc();
        t_thermal();
        t_supply();
        t_nopwm();
        end_of_test();
    end
endmodule
